// ---- rtl/four_port_cell_fifo_interface.sv ----
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R01] Four ports share one transmit and one receive bus, six controls each; code gives each port three (read, write, invalid) plus five shared.
// [R02] Cell-bus compatibility mode uses port 0 only.
// [R03] Both shared buses carry eight data bits plus parity.
// [R04] Transmit read strobes held high during hardware or software reset.
// [R05] No read strobes to a port whose active-low empty input is low.
// [R06] In 53-octet mode start-of-cell precedes the first octet's read strobe.
// [R07] 57-octet frame mapping: frame sync high during first slot of frame.
// [R08] Transmit cell sync low on last octet's read strobe, high otherwise.
// [R09] Octets captured on rising write strobe; cell length sets pulse count.
// [R10] Write into a full receive port drives write-error output low.
// [R11] Receive cell sync low during final octet, high otherwise.
// [R12] Invalid low on first octet, high on last five if check failed.
// [R13] Outside logic discards cells flagged invalid.
// [R14] Validation bit 15 turns error and frame sync into start-of-cell marks.
// [R15] Start-of-cell marks valid only in 53-octet mode.
// [R16] One receive sync marker for ports 0 to 2, another for port 3.
// [R17] Flag bus: empties on bits 0 to 3, fulls on bits 4 to 7.
// [R18] One read strobe at a time; whole cell before switching ports.
module four_port_cell_fifo_interface #(
   parameter int TX_FIFO_DEPTH = 8
) (
   input  wire logic        CLOCK_IN,
   input  wire logic        SRST_IN,
   input  wire logic [7:0]  REG_ADDR_IN,
   input  wire logic [15:0] REG_WDATA_IN,
   input  wire logic        REG_WR_IN,
   input  wire logic        REG_RD_IN,
   output logic [15:0]      REG_RDATA_OUT,
   input  wire logic [8:0]  TX_CELL_DATA_IN,
   input  wire logic [7:0]  PORT_FLAG_INPUTS_IN,
   output logic [8:0]       RX_CELL_DATA_OUT,
   output logic [16:0]      PORT_STROBE_OUTPUTS_OUT,
   output logic             TX_VALID_OUT,
   output logic [8:0]       TX_DATA_OUT,
   output logic             TX_LAST_OUT,
   output logic [1:0]       TX_PORT_OUT,
   input  wire logic        TX_READY_IN,
   input  wire logic        RX_VALID_IN,
   input  wire logic [8:0]  RX_DATA_IN,
   input  wire logic [3:0]  RX_PORT_MASK_IN,
   input  wire logic        RX_BAD_IN,
   output logic             RX_READY_OUT
);
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_STROBE, TX_WAIT, TX_PUSH}
      tx_state_e;
   typedef enum logic {RX_IDLE, RX_LOW} rx_state_e;

   // Register file
   logic [15:0] cell_validation_control_q;
   logic [15:0] cell_validation_control_d;
   logic [15:0] mode_q;
   logic [15:0] mode_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;

   // Pin synchronisers
   logic [7:0]  flags_meta_q;
   logic [7:0]  flags_q;
   logic [8:0]  txd_meta_q;
   logic [8:0]  txd_q;

   // Transmit side
   tx_state_e   tx_state_q;
   tx_state_e   tx_state_d;
   logic [1:0]  tx_port_q;
   logic [1:0]  tx_port_d;
   logic [1:0]  rr_q;
   logic [1:0]  rr_d;
   logic [5:0]  tx_cnt_q;
   logic [5:0]  tx_cnt_d;
   logic [1:0]  tx_wait_q;
   logic [1:0]  tx_wait_d;
   logic [3:0]  tx_slot_q;
   logic [3:0]  tx_slot_d;
   logic [3:0]  tx_rd_q;
   logic [3:0]  tx_rd_d;
   logic        tx_sync_q;
   logic        tx_sync_d;
   logic        tx_fs_q;
   logic        tx_fs_d;
   fifo_port_pkg::tx_word_s tx_word_q;
   fifo_port_pkg::tx_word_s tx_word_d;
   fifo_port_pkg::tx_word_s fifo_out;
   logic        tx_push;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic        found;
   logic [1:0]  cand;

   // Receive side
   rx_state_e   rx_state_q;
   rx_state_e   rx_state_d;
   logic [5:0]  rx_cnt_q;
   logic [5:0]  rx_cnt_d;
   logic [3:0]  rx_mask_q;
   logic [3:0]  rx_mask_d;
   logic        rx_bad_q;
   logic        rx_bad_d;
   logic [8:0]  rx_data_q;
   logic [8:0]  rx_data_d;
   logic [3:0]  rx_wr_q;
   logic [3:0]  rx_wr_d;
   logic [3:0]  rx_inv_q;
   logic [3:0]  rx_inv_d;
   logic        rx_sync012_q;
   logic        rx_sync012_d;
   logic        rx_sync3_q;
   logic        rx_sync3_d;
   logic        rx_err_q;
   logic        rx_err_d;
   logic        rx_ready_q;
   logic        rx_ready_d;
   logic [3:0]  mask_cur;
   logic        bad_cur;
   logic        rx_last;

   // Shared mode decode
   logic [5:0]  len;
   logic        soft_rst;
   logic        len53;
   logic        soc_mode;
   logic [3:0]  port_en;

   assign len      = fifo_port_pkg::cell_len(
                        mode_q[fifo_port_pkg::LEN_LSB +: 2]);
   assign soft_rst = mode_q[fifo_port_pkg::SOFT_RST_BIT];
   assign len53    = (mode_q[fifo_port_pkg::LEN_LSB +: 2]
                      == fifo_port_pkg::LEN_SEL_53);
   assign soc_mode = cell_validation_control_q[fifo_port_pkg::SOC_MODE_BIT]
                     && len53; // see [R15]
   assign port_en  = mode_q[fifo_port_pkg::COMPAT_BIT]
                     ? 4'h1 : 4'hf; // see [R02]

   always_comb
   begin
      cell_validation_control_d = cell_validation_control_q;
      mode_d     = mode_q;
      rdata_d    = 16'h0000;
      if (REG_WR_IN)
      begin
         case (REG_ADDR_IN)
            fifo_port_pkg::CELL_VALIDATION_CONTROL_ADDR: cell_validation_control_d = REG_WDATA_IN;
            fifo_port_pkg::MODE_ADDR:     mode_d     = REG_WDATA_IN;
            default:                      ;
         endcase
      end
      if (REG_RD_IN)
      begin
         case (REG_ADDR_IN)
            fifo_port_pkg::CELL_VALIDATION_CONTROL_ADDR: rdata_d = cell_validation_control_q;
            fifo_port_pkg::MODE_ADDR:     rdata_d = mode_q;
            fifo_port_pkg::STATUS_ADDR:
               rdata_d = {4'h0, flags_q, rx_state_q == RX_LOW
                          || rx_cnt_q != '0, tx_state_q != TX_IDLE, tx_port_q};
            default:                      rdata_d = 16'h0000;
         endcase
      end
   end

   // Transmit cell fetch
   always_comb
   begin
      tx_state_d = tx_state_q;
      tx_port_d  = tx_port_q;
      rr_d       = rr_q;
      tx_cnt_d   = tx_cnt_q;
      tx_wait_d  = tx_wait_q;
      tx_slot_d  = tx_slot_q;
      tx_word_d  = tx_word_q;
      tx_push    = 1'b0;
      found      = 1'b0;
      cand       = rr_q;
      // Round robin from the port after the last one served
      for (int i = 1; i <= fifo_port_pkg::NUM_PORTS; i++)
      begin
         if (!found && flags_q[2'(rr_q + 2'(i))] // see [R05] [R17]
             && port_en[2'(rr_q + 2'(i))])
         begin
            found = 1'b1;
            cand  = 2'(rr_q + 2'(i));
         end
      end
      case (tx_state_q)
         TX_IDLE:
         begin
            if (found && mode_q[fifo_port_pkg::TX_EN_BIT])
            begin
               tx_port_d  = cand;
               tx_cnt_d   = 6'h00;
               tx_state_d = len53 ? TX_START : TX_STROBE; // see [R06]
            end
         end
         TX_START:  tx_state_d = TX_STROBE;
         TX_STROBE:
         begin
            tx_wait_d  = 2'h0;
            tx_state_d = TX_WAIT;
         end
         TX_WAIT:
         begin
            tx_wait_d = tx_wait_q + 1'b1;
            if (tx_wait_q == fifo_port_pkg::TX_SETTLE_CYCLES - 2'h1)
            begin
               tx_word_d.port = tx_port_q;
               tx_word_d.last = (tx_cnt_q == len - 6'h01);
               tx_word_d.data = txd_q; // see [R03]
               tx_state_d     = TX_PUSH;
            end
         end
         TX_PUSH:
         begin
            tx_push = 1'b1;
            // The full buffer stalls further strobes, so no octet is lost
            if (fifo_in_ready)
            begin
               if (tx_word_q.last)
               begin
                  rr_d       = tx_port_q;
                  tx_slot_d  = (tx_slot_q == fifo_port_pkg::SLOTS_PER_FRAME
                                - 4'h1) ? 4'h0 : tx_slot_q + 4'h1;
                  tx_state_d = TX_IDLE; // see [R18]
               end
               else
               begin
                  tx_cnt_d   = tx_cnt_q + 6'h01;
                  tx_state_d = TX_STROBE;
               end
            end
         end
         default:   tx_state_d = TX_IDLE;
      endcase
      if (soft_rst)
      begin
         tx_state_d = TX_IDLE;
         tx_cnt_d   = 6'h00;
         tx_slot_d  = 4'h0;
      end
      // Strobes follow the next state so they come straight from flops
      tx_rd_d   = 4'hf;
      tx_sync_d = 1'b1;
      if (tx_state_d == TX_STROBE)
      begin
         tx_rd_d[tx_port_d] = 1'b0; // see [R18]
         tx_sync_d = (tx_cnt_d != len - 6'h01); // see [R08]
      end
      if (len53)
      begin
         tx_fs_d = (tx_state_d == TX_START); // see [R06] [R14]
      end
      else
      begin
         tx_fs_d = mode_q[fifo_port_pkg::FRAME_MAP_BIT] // see [R07]
                   && (mode_q[fifo_port_pkg::LEN_LSB +: 2]
                       == fifo_port_pkg::LEN_SEL_57)
                   && (tx_state_d != TX_IDLE) && (tx_slot_d == 4'h0);
      end
   end

   // Receive cell write
   always_comb
   begin
      rx_state_d   = rx_state_q;
      rx_cnt_d     = rx_cnt_q;
      rx_mask_d    = rx_mask_q;
      rx_bad_d     = rx_bad_q;
      rx_data_d    = rx_data_q;
      rx_wr_d      = 4'hf;
      rx_inv_d     = 4'h0;
      rx_sync012_d = 1'b1;
      rx_sync3_d   = 1'b1;
      rx_err_d     = !soc_mode;
      mask_cur     = (rx_cnt_q == 6'h00) ? (RX_PORT_MASK_IN & port_en)
                                         : rx_mask_q;
      bad_cur      = (rx_cnt_q == 6'h00) ? RX_BAD_IN : (rx_bad_q | RX_BAD_IN);
      rx_last      = (rx_cnt_q == len - 6'h01);
      case (rx_state_q)
         RX_IDLE:
         begin
            if (RX_VALID_IN && rx_ready_q)
            begin
               rx_mask_d    = mask_cur;
               rx_bad_d     = bad_cur;
               rx_data_d    = RX_DATA_IN; // see [R03]
               rx_wr_d      = ~mask_cur; // see [R09]
               rx_sync012_d = !(rx_last && |mask_cur[2:0]); // see [R11] [R16]
               rx_sync3_d   = !(rx_last && mask_cur[3]); // see [R11] [R16]
               // Count 0 is never in the tail, so the first octet stays low
               for (int p = 0; p < fifo_port_pkg::NUM_PORTS; p++)
               begin
                  rx_inv_d[p] = mask_cur[p] && bad_cur // see [R12]
                     && (rx_cnt_q >= len - fifo_port_pkg::INVALID_TAIL);
               end
               if (soc_mode)
               begin
                  rx_err_d = (rx_cnt_q == 6'h00); // see [R14]
               end
               else
               begin
                  rx_err_d = !(|(mask_cur & ~flags_q[7:4])); // see [R10]
               end
               rx_state_d = RX_LOW;
            end
         end
         RX_LOW:
         begin
            // Strobe rises here; data stays put until the next accept
            rx_cnt_d   = rx_last ? 6'h00 : rx_cnt_q + 6'h01;
            rx_state_d = RX_IDLE;
         end
         default:      rx_state_d = RX_IDLE;
      endcase
      if (soft_rst)
      begin
         rx_state_d = RX_IDLE;
         rx_cnt_d   = 6'h00;
         rx_wr_d    = 4'hf;
      end
      rx_ready_d = (rx_state_d == RX_IDLE) && !soft_rst
                   && mode_q[fifo_port_pkg::RX_EN_BIT];
   end

   always_ff @(posedge CLOCK_IN)
   begin
      flags_meta_q <= PORT_FLAG_INPUTS_IN;
      flags_q      <= flags_meta_q;
      txd_meta_q   <= TX_CELL_DATA_IN;
      txd_q        <= txd_meta_q;
      if (SRST_IN)
      begin
         cell_validation_control_q   <= fifo_port_pkg::CELL_VALIDATION_CONTROL_RESET;
         mode_q       <= fifo_port_pkg::MODE_RESET;
         rdata_q      <= 16'h0000;
         tx_state_q   <= TX_IDLE;
         tx_port_q    <= 2'h0;
         rr_q         <= 2'h3;
         tx_cnt_q     <= 6'h00;
         tx_wait_q    <= 2'h0;
         tx_slot_q    <= 4'h0;
         tx_word_q    <= '0;
         tx_rd_q      <= 4'hf; // see [R04]
         tx_sync_q    <= 1'b1;
         tx_fs_q      <= 1'b0;
         rx_state_q   <= RX_IDLE;
         rx_cnt_q     <= 6'h00;
         rx_mask_q    <= 4'h0;
         rx_bad_q     <= 1'b0;
         rx_data_q    <= 9'h000;
         rx_wr_q      <= 4'hf;
         rx_inv_q     <= 4'h0;
         rx_sync012_q <= 1'b1;
         rx_sync3_q   <= 1'b1;
         rx_err_q     <= 1'b1;
         rx_ready_q   <= 1'b0;
      end
      else
      begin
         cell_validation_control_q   <= cell_validation_control_d;
         mode_q       <= mode_d;
         rdata_q      <= rdata_d;
         tx_state_q   <= tx_state_d;
         tx_port_q    <= tx_port_d;
         rr_q         <= rr_d;
         tx_cnt_q     <= tx_cnt_d;
         tx_wait_q    <= tx_wait_d;
         tx_slot_q    <= tx_slot_d;
         tx_word_q    <= tx_word_d;
         tx_rd_q      <= tx_rd_d; // see [R04]
         tx_sync_q    <= tx_sync_d;
         tx_fs_q      <= tx_fs_d;
         rx_state_q   <= rx_state_d;
         rx_cnt_q     <= rx_cnt_d;
         rx_mask_q    <= rx_mask_d;
         rx_bad_q     <= rx_bad_d;
         rx_data_q    <= rx_data_d;
         rx_wr_q      <= rx_wr_d;
         rx_inv_q     <= rx_inv_d;
         rx_sync012_q <= rx_sync012_d;
         rx_sync3_q   <= rx_sync3_d;
         rx_err_q     <= rx_err_d;
         rx_ready_q   <= rx_ready_d;
      end
   end

   cell_fifo #(
      .WIDTH ($bits(fifo_port_pkg::tx_word_s)),
      .DEPTH (TX_FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_in        (CLOCK_IN),
      .srst_in       (SRST_IN || soft_rst),
      .in_valid_in   (tx_push),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (tx_word_q),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (TX_READY_IN),
      .out_data_out  (fifo_out)
   );

   assign TX_VALID_OUT  = fifo_out_valid;
   assign TX_DATA_OUT   = fifo_out.data;
   assign TX_LAST_OUT   = fifo_out.last;
   assign TX_PORT_OUT   = fifo_out.port;
   assign REG_RDATA_OUT = rdata_q;
   assign RX_READY_OUT  = rx_ready_q;
   assign RX_CELL_DATA_OUT = rx_data_q;
   // Seventeen controls, three per port plus five shared, gathered onto one strobe bus
   assign PORT_STROBE_OUTPUTS_OUT = {tx_fs_q, tx_rd_q, tx_sync_q, rx_err_q,
                                     rx_sync3_q, rx_sync012_q, rx_inv_q,
                                     rx_wr_q}; // see [R01]
endmodule
`default_nettype wire

// ---- rtl/fifo_port_pkg.sv ----
package fifo_port_pkg;

   localparam int NUM_PORTS = 4;

   // Register byte offsets
   localparam logic [7:0] CELL_VALIDATION_CONTROL_ADDR = 8'h14;
   localparam logic [7:0] MODE_ADDR     = 8'h18;
   localparam logic [7:0] STATUS_ADDR   = 8'h1c;

   // Values after reset
   localparam logic [15:0] CELL_VALIDATION_CONTROL_RESET = 16'h0000;
   localparam logic [15:0] MODE_RESET     = 16'h0000;

   // Field positions
   localparam int SOC_MODE_BIT  = 15;
   localparam int LEN_LSB       = 0;
   localparam int COMPAT_BIT    = 2;
   localparam int FRAME_MAP_BIT = 3;
   localparam int TX_EN_BIT     = 4;
   localparam int RX_EN_BIT     = 5;
   localparam int SOFT_RST_BIT  = 6;

   // Cell length select codes
   localparam logic [1:0] LEN_SEL_53 = 2'h0;
   localparam logic [1:0] LEN_SEL_57 = 2'h1;
   localparam logic [1:0] LEN_SEL_52 = 2'h2;
   localparam logic [1:0] LEN_SEL_48 = 2'h3;

   // Cycle, octet and slot counts
   localparam logic [1:0] TX_SETTLE_CYCLES = 2'h3;
   localparam logic [5:0] INVALID_TAIL     = 6'h05;
   localparam logic [3:0] SLOTS_PER_FRAME  = 4'hc;

   typedef struct packed {
      logic [1:0] port;
      logic       last;
      logic [8:0] data;
   } tx_word_s;

   function automatic logic [5:0] cell_len(input logic [1:0] sel);
      case (sel)
         LEN_SEL_57: cell_len = 6'h39;
         LEN_SEL_52: cell_len = 6'h34;
         LEN_SEL_48: cell_len = 6'h30;
         default:    cell_len = 6'h35;
      endcase
   endfunction

endpackage

// ---- rtl/cell_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module cell_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_in,
   input  wire logic             srst_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    wr_ptr_d;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW-1:0]    rd_ptr_d;
   logic [AW:0]      count_q;
   logic [AW:0]      count_d;
   logic             push;
   logic             pop;

   assign in_ready_out  = (count_q != (AW+1)'(DEPTH));
   assign out_valid_out = (count_q != '0);
   assign out_data_out  = mem_q[rd_ptr_q];
   assign push = in_valid_in && in_ready_out;
   assign pop  = out_valid_out && out_ready_in;

   always_comb
   begin
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      count_d  = count_q;
      if (push)
      begin
         wr_ptr_d = (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
         rd_ptr_d = (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop)
      begin
         count_d = count_q + 1'b1;
      end
      else if (pop && !push)
      begin
         count_d = count_q - 1'b1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end
      else
      begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         count_q  <= count_d;
      end
   end

   // Storage needs no reset; count gates what is visible
   always_ff @(posedge clk_in)
   begin
      if (push)
      begin
         mem_q[wr_ptr_q] <= in_data_in;
      end
   end
endmodule
`default_nettype wire

// ---- tb/four_port_cell_fifo_interface_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module four_port_cell_fifo_interface_props (
   input wire logic        CLOCK_IN,
   input wire logic        SRST_IN,
   input wire logic        REG_RD_IN,
   input wire logic [15:0] REG_RDATA_OUT,
   input wire logic [16:0] PORT_STROBE_OUTPUTS_OUT,
   input wire logic        RX_VALID_IN,
   input wire logic        RX_READY_OUT
);
   default clocking cb @(posedge CLOCK_IN);
   endclocking
   default disable iff (SRST_IN);
   wire logic [16:0] so = PORT_STROBE_OUTPUTS_OUT;
   property p_rst_idle;
      disable iff (1'b0) SRST_IN |=> so[15:11] == 5'h1f && so[3:0] == 4'hf;
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("strobe in reset");
   property p_one_rd;
      $onehot0(~so[15:12]);
   endproperty
   a_one_rd: assert property (p_one_rd)
      else $error("two read strobes");
   property p_tx_sync;
      !so[11] |-> so[15:12] != 4'hf;
   endproperty
   a_tx_sync: assert property (p_tx_sync)
      else $error("tx sync off strobe");
   property p_wr_pulse;
      so[3:0] != 4'hf |=> so[3:0] == 4'hf;
   endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("long write strobe");
   property p_rx_sync;
      !so[8] |-> so[2:0] != 3'h7;
   endproperty
   a_rx_sync: assert property (p_rx_sync)
      else $error("rx sync off strobe");
   property p_rx_sync3;
      !so[9] |-> !so[3];
   endproperty
   a_rx_sync3: assert property (p_rx_sync3)
      else $error("port 3 sync off strobe");
   property p_inv;
      (so[7:4] & so[3:0]) == 4'h0;
   endproperty
   a_inv: assert property (p_inv)
      else $error("invalid off strobe");
   property p_rx_gap;
      RX_VALID_IN && RX_READY_OUT |=> !RX_READY_OUT ##1 so[3:0] == 4'hf;
   endproperty
   a_rx_gap: assert property (p_rx_gap)
      else $error("rx accept pacing");
   property p_rdata;
      !REG_RD_IN |=> REG_RDATA_OUT == 16'h0000;
   endproperty
   a_rdata: assert property (p_rdata)
      else $error("stray read data");
   c_tx_last: cover property (!so[11]);
   c_rx_last: cover property (!so[8]);
   c_inv: cover property (so[7:4] != 4'h0);
endmodule
`default_nettype wire

// ---- tb/cell_fifo_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cell_fifo_model (
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   input  wire logic [16:0] strb_in,
   input  wire logic [3:0]  load_in,
   input  wire logic [3:0]  full_n_in,
   input  wire logic [5:0]  len_in,
   output logic [8:0]       data_out,
   output logic [7:0]       flags_out,
   output logic [3:0]       bad_out,
   output logic [3:0][15:0] rd_cnt_out,
   output logic [3:0][15:0] wr_cnt_out
);
   logic [16:0] prev_q;
   logic [3:0]  avail_q;
   logic [5:0]  idx_q;
   logic [2:0]  hold_q;
   logic [7:0]  oct;
   assign flags_out = {full_n_in, avail_q};
   always @(posedge clk_in)
   begin
      prev_q <= strb_in;
      if (srst_in)
      begin
         avail_q <= 4'h0;
         idx_q <= 6'h00;
         hold_q <= 3'h0;
         data_out <= 9'h000;
         bad_out <= 4'h0;
         rd_cnt_out <= '0;
         wr_cnt_out <= '0;
      end
      else
      begin
         // Bus drifts once hold time is over so stale data cannot pass
         if (hold_q != 3'h0)
            hold_q <= hold_q - 3'h1;
         else
            data_out <= ~data_out;
         for (int p = 0; p < 4; p++)
         begin
            if (load_in[p])
               avail_q[p] <= 1'b1;
            if (prev_q[12+p] && !strb_in[12+p])
            begin
               oct = {p[1:0], idx_q};
               data_out <= {^oct, oct};
               hold_q <= 3'h4;
               rd_cnt_out[p] <= rd_cnt_out[p] + 16'h1;
               idx_q <= (idx_q == len_in - 6'h1) ? 6'h00 : idx_q + 6'h1;
               if (idx_q == len_in - 6'h1)
                  avail_q[p] <= 1'b0;
            end
            if (!prev_q[p] && strb_in[p])
               wr_cnt_out[p] <= wr_cnt_out[p] + 16'h1;
            if (!strb_in[p] && strb_in[4+p])
               bad_out[p] <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb/four_port_cell_fifo_interface_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module four_port_cell_fifo_interface_tb_top;
   logic             clk = 1'b0;
   logic             srst = 1'b1;
   logic [7:0]       addr = 8'h00;
   logic [15:0]      wdata = 16'h0000;
   logic             wr_en = 1'b0;
   logic             rd_en = 1'b0;
   logic [15:0]      rdata;
   logic [8:0]       txd;
   logic [7:0]       flags;
   logic [16:0]      strb;
   logic             tx_valid, tx_last, rx_ready;
   logic [8:0]       tx_data, rx_out;
   logic [1:0]       tx_port;
   logic             tx_ready = 1'b1;
   logic             rx_valid = 1'b0;
   logic [8:0]       rx_data = 9'h000;
   logic [3:0]       rx_mask = 4'h0;
   logic             rx_bad = 1'b0;
   logic [3:0]       load = 4'h0;
   logic [3:0]       full_n = 4'hf;
   logic [3:0]       bad;
   logic [3:0][15:0] rd_cnt, wr_cnt, snap;
   logic [5:0]       tx_idx = 6'h00;
   logic [7:0]       oct_e;
   int n_mismatch = 0, tests_run = 0, cyc = 0, tx_got = 0;
   int n_sync = 0, n_fs = 0, n_err = 0, n_soc = 0;
   int lens [4] = '{53, 57, 52, 48};
   localparam logic [5:0] LEN = 6'd53;
   always #20 clk = ~clk;
   four_port_cell_fifo_interface #(.TX_FIFO_DEPTH(8)) u_dut (
      .CLOCK_IN(clk), .SRST_IN(srst), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .REG_WR_IN(wr_en), .REG_RD_IN(rd_en),
      .REG_RDATA_OUT(rdata), .TX_CELL_DATA_IN(txd),
      .PORT_FLAG_INPUTS_IN(flags), .RX_CELL_DATA_OUT(rx_out),
      .PORT_STROBE_OUTPUTS_OUT(strb), .TX_VALID_OUT(tx_valid),
      .TX_DATA_OUT(tx_data), .TX_LAST_OUT(tx_last), .TX_PORT_OUT(tx_port),
      .TX_READY_IN(tx_ready), .RX_VALID_IN(rx_valid), .RX_DATA_IN(rx_data),
      .RX_PORT_MASK_IN(rx_mask), .RX_BAD_IN(rx_bad),
      .RX_READY_OUT(rx_ready));
   cell_fifo_model u_far (
      .clk_in(clk), .srst_in(srst), .strb_in(strb), .load_in(load),
      .full_n_in(full_n), .len_in(LEN), .data_out(txd), .flags_out(flags),
      .bad_out(bad), .rd_cnt_out(rd_cnt), .wr_cnt_out(wr_cnt));
   task automatic end_sim;
      $display("Checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         $display("BAD %s exp %h got %h", nm, e, g);
         n_mismatch++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a,
                        input logic [15:0] e);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(posedge clk);
      chk(nm, e, rdata);
   endtask
   task automatic pulse_load(input logic [3:0] m);
      load <= m;
      @(posedge clk);
      load <= 4'h0;
   endtask
   task automatic wait_tx(input int n);
      for (int i = 0; i < 8000 && tx_got < n; i++)
         @(posedge clk);
      repeat (10) @(posedge clk);
      chk("tx_count", 16'(n), 16'(tx_got));
   endtask
   task automatic rx_cell(input logic [3:0] m, input logic b, input int n);
      for (int i = 0; i < n; i++)
      begin
         rx_valid <= 1'b1;
         rx_data <= 9'(i);
         rx_mask <= m;
         rx_bad <= b;
         @(posedge clk);
         while (rx_ready !== 1'b1)
            @(posedge clk);
      end
      rx_valid <= 1'b0;
      repeat (4) @(posedge clk);
      chk("rx_data", 16'(n - 1), 16'(rx_out));
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         end_sim;
      end
   end
   always @(posedge clk)
   begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
      begin
         oct_e = {tx_port, tx_idx};
         chk("tx_data", {7'h00, ^oct_e, oct_e}, 16'(tx_data));
         chk("tx_last", 16'(tx_idx == LEN - 6'h1), 16'(tx_last));
         tx_idx = (tx_idx == LEN - 6'h1) ? 6'h00 : tx_idx + 6'h1;
         tx_got++;
      end
      n_sync += int'(strb[11] === 1'b0);
      n_fs += int'(strb[16] === 1'b1);
      n_err += int'(strb[10] === 1'b0);
      n_soc += int'(strb[10] === 1'b1);
   end
   initial
   begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rdchk("cell_validation_control", fifo_port_pkg::CELL_VALIDATION_CONTROL_ADDR, 16'h0000);
      rdchk("mode", fifo_port_pkg::MODE_ADDR, 16'h0000);
      rdchk("unmapped", 8'h00, 16'h0000);
      wr(fifo_port_pkg::CELL_VALIDATION_CONTROL_ADDR, 16'h8000);
      rdchk("cell_validation_control", fifo_port_pkg::CELL_VALIDATION_CONTROL_ADDR, 16'h8000);
      wr(fifo_port_pkg::CELL_VALIDATION_CONTROL_ADDR, 16'h0000);
      // Software reset must keep a waiting cell unread
      pulse_load(4'h2);
      wr(fifo_port_pkg::MODE_ADDR, 16'h0050);
      repeat (40) @(posedge clk);
      chk("rd_p1_held", 16'h0000, rd_cnt[1]);
      n_sync = 0;
      n_fs = 0;
      tx_ready <= 1'b0;
      wr(fifo_port_pkg::MODE_ADDR, 16'h0030);
      repeat (200) @(posedge clk);
      chk("tx_stalled", 16'h0001, 16'(tx_valid));
      tx_ready <= 1'b1;
      wait_tx(53);
      chk("rd_p1", 16'd53, rd_cnt[1]);
      chk("rd_p0", 16'h0000, rd_cnt[0]);
      chk("tx_sync_low", 16'h0001, 16'(n_sync));
      chk("tx_soc", 16'h0001, 16'(n_fs));
      tx_got = 0;
      pulse_load(4'hc);
      wait_tx(106);
      chk("rd_p2", 16'd53, rd_cnt[2]);
      chk("rd_p3", 16'd53, rd_cnt[3]);
      for (int k = 0; k < 4; k++)
      begin
         wr(fifo_port_pkg::MODE_ADDR, 16'h0020 | 16'(k));
         snap = wr_cnt;
         rx_cell(4'h8, 1'b0, lens[k]);
         chk("wr_p3", snap[3] + 16'(lens[k]), wr_cnt[3]);
      end
      wr(fifo_port_pkg::MODE_ADDR, 16'h0020);
      rx_cell(4'h4, 1'b1, 53);
      rx_cell(4'h2, 1'b0, 53);
      chk("bad_p2", 16'h0001, 16'(bad[2]));
      chk("bad_p1", 16'h0000, 16'(bad[1]));
      full_n <= 4'he;
      repeat (4) @(posedge clk);
      n_err = 0;
      rx_cell(4'h1, 1'b0, 53);
      chk("wr_err", 16'd53, 16'(n_err));
      full_n <= 4'hf;
      wr(fifo_port_pkg::MODE_ADDR, 16'h0024);
      snap = wr_cnt;
      rx_cell(4'hf, 1'b0, 53);
      chk("compat_p0", snap[0] + 16'd53, wr_cnt[0]);
      chk("compat_p1", snap[1], wr_cnt[1]);
      wr(fifo_port_pkg::MODE_ADDR, 16'h0020);
      wr(fifo_port_pkg::CELL_VALIDATION_CONTROL_ADDR, 16'h8000);
      repeat (4) @(posedge clk);
      n_soc = 0;
      rx_cell(4'h1, 1'b0, 53);
      chk("rx_soc", 16'h0001, 16'(n_soc));
      end_sim;
   end
endmodule
bind four_port_cell_fifo_interface four_port_cell_fifo_interface_props
   u_props (.CLOCK_IN(CLOCK_IN), .SRST_IN(SRST_IN), .REG_RD_IN(REG_RD_IN),
            .REG_RDATA_OUT(REG_RDATA_OUT),
            .PORT_STROBE_OUTPUTS_OUT(PORT_STROBE_OUTPUTS_OUT),
            .RX_VALID_IN(RX_VALID_IN), .RX_READY_OUT(RX_READY_OUT));
`default_nettype wire
